// file: rtl/ferp_pkg.sv
package ferp_pkg;
	// clock rate and timing figures
	localparam int CLK_MHZ = 40;
	localparam int HOLD_TIME_US = 722;
	localparam int HOLD_CYC = HOLD_TIME_US * CLK_MHZ;
	localparam int READY_TIME_US = 500;
	localparam int READY_CYC = READY_TIME_US * CLK_MHZ;
	// lock and idle run lengths, in bits
	localparam int LOCK_RUN = 40;
	localparam int IDLE_OK_RUN = 10;
	localparam int FEFI_ONES = 84;
	localparam int SSD_WAIT_BITS = 10;
	localparam int GROUP_BITS = 5;
	// descrambler taps for x^11 + x^9 + 1
	localparam int LFSR_W = 11;
	localparam int TAP_A = 10;
	localparam int TAP_B = 8;
	// code-group pairs, first received bit in the msb
	localparam logic [9:0] SSD_PAIR = 10'b11000_10001;
	localparam logic [9:0] ESD_PAIR = 10'b01101_00111;
	localparam logic [9:0] IDLE_PAIR = 10'b11111_11111;
	// nibbles put on the receive bus
	localparam logic [3:0] PRE_NIB = 4'h5;
	localparam logic [3:0] BAD_NIB = 4'he;
	localparam logic [1:0] PRE_COUNT = 2'h2;
	// internal receive bus towards the mac
	typedef struct packed {
		logic [3:0] rxd;
		logic dv;
		logic er;
		logic crs;
	} ferp_mii_rx_t;
	typedef enum logic [1:0] {RX_IDLE, RX_SSD, RX_DATA, RX_BAD} ferp_rx_st_t;
	typedef enum logic [1:0] {LK_DOWN, LK_WAIT, LK_READY, LK_UP} ferp_lk_st_t;
endpackage

// file: rtl/ferp_sym_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module ferp_sym_decoder
	import ferp_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// code group in
	input wire logic [4:0] code,
	input wire logic code_stb,
	// nibble out, one cycle later
	output logic [3:0] nibble,
	output logic bad,
	output logic nibble_stb
);
	// registered 5b to 4b lookup; unknown groups flag bad
	always_ff @(posedge mclk) begin
		if (reset) begin
			nibble <= 4'h0;
			bad <= 1'b0;
			nibble_stb <= 1'b0;
		end else begin
			nibble_stb <= code_stb;
			if (code_stb) begin
				bad <= 1'b0;
				case (code)
					5'b11110: nibble <= 4'h0;
					5'b01001: nibble <= 4'h1;
					5'b10100: nibble <= 4'h2;
					5'b10101: nibble <= 4'h3;
					5'b01010: nibble <= 4'h4;
					5'b01011: nibble <= 4'h5;
					5'b01110: nibble <= 4'h6;
					5'b01111: nibble <= 4'h7;
					5'b10010: nibble <= 4'h8;
					5'b10011: nibble <= 4'h9;
					5'b10110: nibble <= 4'ha;
					5'b10111: nibble <= 4'hb;
					5'b11010: nibble <= 4'hc;
					5'b11011: nibble <= 4'hd;
					5'b11100: nibble <= 4'he;
					5'b11101: nibble <= 4'hf;
					default: begin
						nibble <= 4'h0;
						bad <= 1'b1;
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: rtl/ferp_rx_pcs.sv
// Operation
// RULE1 - line data turned nrzi to nrz, unaligned
// RULE2 - lock after 40 idle bits, load lfsr
// RULE3 - locked: each bit xored with lfsr output
// RULE4 - lock starts the 722 us hold timer
// RULE5 - enough idle restarts the hold timer
// RULE6 - hold expiry drops lock, relock from scratch
// RULE7 - align groups on the 11000 10001 pair
// RULE8 - start pair after idle becomes preamble nibbles
// RULE9 - decode groups until end pair seen
// RULE10 - nibble on rxd, bit 0 is lsb
// RULE11 - valid rises with first start-pair nibble
// RULE12 - valid drops on end, link fail, no signal
// RULE13 - error flags invalid groups while valid
// RULE14 - no link blocks transmit and receive
// RULE15 - 100 and 10 link form status and led
// RULE16 - 500 us energy gives ready, then up
// RULE17 - no auto-negotiation: ready goes straight up
// RULE18 - carrier on two non-adjacent zeros in ten
// RULE19 - switch mode adds transmit to carrier
// RULE20 - idle pair ends carrier; carrier encloses valid
// RULE21 - bad start: error and 1110 per group
// RULE22 - two idles end bad-start error and carrier
// RULE23 - 84 ones then zero signals far fault
// RULE24 - descrambler uses x^11 + x^9 + 1
`timescale 1ns/1ps
`default_nettype none
module ferp_rx_pcs
	import ferp_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_CYC,
	parameter int READY_CYCLES = READY_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// line pins from the recovery front end
	input wire logic rx_nrzi,
	input wire logic rx_bit_toggle,
	input wire logic signal_detect,
	// configuration and status from core logic
	input wire logic an_enable,
	input wire logic an_permit,
	input wire logic link10_ok,
	input wire logic tx_active,
	input wire logic repeater_mode,
	// internal mii receive side
	output ferp_mii_rx_t mii_rx,
	output logic rx_nib_stb,
	// link and status
	output logic link_status,
	output logic link_activity_led_n,
	output logic tx_allow,
	output logic descr_locked,
	output logic far_end_fault
);
	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic tog_d;
	logic nrzi_d;
	logic bit_stb;
	logic nrz;
	logic sig;
	logic [LFSR_W-1:0] scr_hist;
	logic [LFSR_W-1:0] lfsr;
	logic lfsr_out;
	logic pbit;
	logic idle_match;
	logic [5:0] idle_run;
	logic [6:0] ones_run;
	logic [31:0] hold_cnt;
	logic [9:0] win;
	logic [9:0] next_win;
	logic carrier;
	ferp_rx_st_t rx_st;
	logic [3:0] bcnt;
	logic grp_first;
	logic [1:0] pre_cnt;
	logic crs_rx;
	logic end_evt;
	logic [4:0] code;
	logic code_stb;
	logic bad_stb;
	logic [3:0] dec_nib;
	logic dec_bad;
	logic dec_stb;
	ferp_lk_st_t lk_st;
	logic [31:0] lk_cnt;
	logic link_up;
	logic kill;

	// two-flop synchronisers for the line pins
	always_ff @(posedge mclk) begin
		if (reset) begin
			pin_s1 <= 3'h0;
			pin_s2 <= 3'h0;
			tog_d <= 1'b0;
		end else begin
			pin_s1 <= {signal_detect, rx_bit_toggle, rx_nrzi};
			pin_s2 <= pin_s1;
			tog_d <= pin_s2[1];
		end
	end

	// bit strobe, nrz bit, descrambler and carrier detect
	assign bit_stb = pin_s2[1] ^ tog_d;
	assign sig = pin_s2[2];
	assign nrz = pin_s2[0] ^ nrzi_d; // [RULE1]
	assign lfsr_out = lfsr[TAP_A] ^ lfsr[TAP_B]; // [RULE24]
	assign pbit = nrz ^ lfsr_out; // [RULE3]
	assign idle_match = ~nrz == (scr_hist[TAP_A] ^ scr_hist[TAP_B]);
	assign next_win = {win[8:0], pbit};
	assign link_up = lk_st == LK_UP;
	assign kill = !link_up || !sig;

	// two zeros at least two bits apart anywhere in the window
	function automatic logic two_zeros(input logic [9:0] w);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 10; i++) begin
			for (int j = i + 2; j < 10; j++) begin
				if (!w[i] && !w[j])
					hit = 1'b1;
			end
		end
		return hit;
	endfunction
	assign carrier = two_zeros(next_win); // [RULE18]

	// nrzi history and scrambled-bit history
	always_ff @(posedge mclk) begin
		if (reset) begin
			nrzi_d <= 1'b0;
			scr_hist <= '0;
		end else if (bit_stb) begin
			nrzi_d <= pin_s2[0];
			scr_hist <= {scr_hist[LFSR_W-2:0], nrz};
		end
	end

	// lock acquisition, hold timer and loss of lock
	always_ff @(posedge mclk) begin
		if (reset) begin
			descr_locked <= 1'b0;
			idle_run <= 6'h0;
			lfsr <= '0;
			hold_cnt <= 32'h0;
		end else if (!descr_locked) begin
			if (bit_stb) begin
				if (!idle_match) begin
					idle_run <= 6'h0;
				end else if (idle_run == 6'(LOCK_RUN - 1)) begin
					descr_locked <= 1'b1; // [RULE2]
					lfsr <= ~{scr_hist[LFSR_W-2:0], nrz};
					hold_cnt <= 32'(HOLD_CYCLES - 1); // [RULE4]
				end else begin
					idle_run <= idle_run + 6'h1;
				end
			end
		end else begin
			if (bit_stb)
				lfsr <= {lfsr[LFSR_W-2:0], lfsr_out};
			// every idle bit from the tenth of a run onwards restarts the countdown
			if (bit_stb && pbit && ones_run >= 7'(IDLE_OK_RUN - 1))
				hold_cnt <= 32'(HOLD_CYCLES - 1); // [RULE5]
			else if (hold_cnt == 32'h0) begin
				descr_locked <= 1'b0; // [RULE6]
				idle_run <= 6'h0;
			end else
				hold_cnt <= hold_cnt - 32'h1;
		end
	end

	// runs of plain ones and far-end fault idle
	always_ff @(posedge mclk) begin
		if (reset) begin
			ones_run <= 7'h0;
			far_end_fault <= 1'b0;
		end else if (!descr_locked) begin
			ones_run <= 7'h0;
		end else if (bit_stb) begin
			if (pbit) begin
				if (ones_run != 7'h7f)
					ones_run <= ones_run + 7'h1;
				if (ones_run == 7'(FEFI_ONES + 1))
					far_end_fault <= 1'b0;
			end else begin
				ones_run <= 7'h0;
				if (ones_run == 7'(FEFI_ONES))
					far_end_fault <= 1'b1; // [RULE23]
			end
		end
	end

	// receive framing state machine
	always_ff @(posedge mclk) begin
		if (reset) begin
			rx_st <= RX_IDLE;
			win <= IDLE_PAIR;
			bcnt <= 4'h0;
			grp_first <= 1'b0;
			pre_cnt <= 2'h0;
			crs_rx <= 1'b0;
			end_evt <= 1'b0;
			code <= 5'h0;
			code_stb <= 1'b0;
			bad_stb <= 1'b0;
		end else begin
			end_evt <= 1'b0;
			code_stb <= 1'b0;
			bad_stb <= 1'b0;
			if (pre_cnt != 2'h0)
				pre_cnt <= pre_cnt - 2'h1;
			if (kill || !descr_locked) begin
				rx_st <= RX_IDLE; // [RULE14]
				win <= IDLE_PAIR;
				crs_rx <= 1'b0;
				end_evt <= 1'b1;
				pre_cnt <= 2'h0;
			end else if (bit_stb) begin
				win <= next_win;
				case (rx_st)
					RX_IDLE: begin
						bcnt <= 4'h0;
						// end-delimiter tail keeps carrier until idle pair
						if (next_win == IDLE_PAIR) begin
							crs_rx <= 1'b0; // [RULE20]
						end else if (carrier && !crs_rx) begin
							crs_rx <= 1'b1;
							rx_st <= RX_SSD;
						end
					end
					RX_SSD: begin
						bcnt <= bcnt + 4'h1;
						if (next_win == SSD_PAIR) begin
							rx_st <= RX_DATA; // [RULE7]
							pre_cnt <= PRE_COUNT; // [RULE8]
							bcnt <= 4'h0;
							grp_first <= 1'b1;
						end else if (bcnt == 4'(SSD_WAIT_BITS - 1)) begin
							rx_st <= RX_BAD;
							bcnt <= 4'h0;
						end
					end
					RX_DATA: begin
						bcnt <= bcnt + 4'h1;
						if (next_win == IDLE_PAIR) begin
							rx_st <= RX_IDLE; // [RULE20]
							crs_rx <= 1'b0;
							end_evt <= 1'b1;
						end else if (bcnt == 4'(GROUP_BITS - 1)) begin
							bcnt <= 4'h0;
							grp_first <= 1'b0;
							if (next_win == ESD_PAIR) begin
								rx_st <= RX_IDLE; // [RULE9]
								end_evt <= 1'b1;
							end else if (!grp_first) begin
								code <= next_win[9:5];
								code_stb <= 1'b1;
							end
						end
					end
					RX_BAD: begin
						bcnt <= bcnt + 4'h1;
						if (next_win == IDLE_PAIR) begin
							rx_st <= RX_IDLE; // [RULE22]
							crs_rx <= 1'b0;
						end else if (bcnt == 4'(GROUP_BITS - 1)) begin
							bcnt <= 4'h0;
							bad_stb <= 1'b1; // [RULE21]
						end
					end
					default: rx_st <= RX_IDLE;
				endcase
			end
		end
	end

	ferp_sym_decoder u_dec (
		.mclk(mclk),
		.reset(reset),
		.code(code),
		.code_stb(code_stb),
		.nibble(dec_nib),
		.bad(dec_bad),
		.nibble_stb(dec_stb)
	);

	// mii receive outputs
	always_ff @(posedge mclk) begin
		if (reset) begin
			mii_rx <= '0;
			rx_nib_stb <= 1'b0;
		end else begin
			rx_nib_stb <= 1'b0;
			mii_rx.crs <= crs_rx || (!repeater_mode && tx_active); // [RULE19]
			if (end_evt || kill) begin
				mii_rx.dv <= 1'b0; // [RULE12]
				mii_rx.er <= 1'b0;
			end else if (pre_cnt != 2'h0) begin
				mii_rx.rxd <= PRE_NIB; // [RULE8]
				mii_rx.dv <= 1'b1; // [RULE11]
				mii_rx.er <= 1'b0;
				rx_nib_stb <= 1'b1;
			end else if (dec_stb) begin
				mii_rx.rxd <= dec_nib; // [RULE10]
				mii_rx.er <= dec_bad; // [RULE13]
				rx_nib_stb <= 1'b1;
			end else if (bad_stb) begin
				mii_rx.rxd <= BAD_NIB; // [RULE21]
				mii_rx.er <= 1'b1;
				rx_nib_stb <= 1'b1;
			end else if (rx_st == RX_IDLE) begin
				mii_rx.er <= 1'b0; // [RULE22]
			end
		end
	end

	// link monitor
	always_ff @(posedge mclk) begin
		if (reset) begin
			lk_st <= LK_DOWN;
			lk_cnt <= 32'h0;
		end else if (!sig) begin
			lk_st <= LK_DOWN;
		end else begin
			case (lk_st)
				LK_DOWN: begin
					lk_st <= LK_WAIT;
					lk_cnt <= 32'(READY_CYCLES - 1);
				end
				LK_WAIT: begin
					if (lk_cnt == 32'h0)
						lk_st <= LK_READY; // [RULE16]
					else
						lk_cnt <= lk_cnt - 32'h1;
				end
				LK_READY: begin
					if (!an_enable || an_permit)
						lk_st <= LK_UP; // [RULE16] [RULE17]
				end
				LK_UP: begin
					if (!descr_locked)
						lk_st <= LK_DOWN;
				end
				default: lk_st <= LK_DOWN;
			endcase
		end
	end

	// combined link status, led and transmit permission
	always_ff @(posedge mclk) begin
		if (reset) begin
			link_status <= 1'b0;
			link_activity_led_n <= 1'b1;
			tx_allow <= 1'b0;
		end else begin
			link_status <= link_up || link10_ok; // [RULE15]
			link_activity_led_n <= !(link_up || link10_ok);
			tx_allow <= link_up; // [RULE14]
		end
	end

	property p_lock_gain;
		@(posedge mclk) disable iff (reset)
		$rose(descr_locked) |-> $past(idle_run) == 6'(LOCK_RUN - 1);
	endproperty
	a_lock_gain: assert property (p_lock_gain) // [RULE2]
		else $error("lock without full idle run");

	property p_hold_start;
		@(posedge mclk) disable iff (reset)
		$rose(descr_locked) |-> hold_cnt == 32'(HOLD_CYCLES - 1);
	endproperty
	a_hold_start: assert property (p_hold_start) // [RULE4]
		else $error("hold timer not started at lock");

	property p_hold_drop;
		@(posedge mclk) disable iff (reset)
		descr_locked && hold_cnt == 32'h0 && !bit_stb |=> !descr_locked;
	endproperty
	a_hold_drop: assert property (p_hold_drop) // [RULE6]
		else $error("lock kept after hold expiry");

	property p_crs_encloses;
		@(posedge mclk) disable iff (reset)
		mii_rx.dv |-> mii_rx.crs;
	endproperty
	a_crs_encloses: assert property (p_crs_encloses) // [RULE20]
		else $error("valid outside carrier");

	property p_preamble;
		@(posedge mclk) disable iff (reset)
		$rose(mii_rx.dv) |-> rx_nib_stb && mii_rx.rxd == PRE_NIB ##1
			rx_nib_stb && mii_rx.rxd == PRE_NIB;
	endproperty
	a_preamble: assert property (p_preamble) // [RULE8]
		else $error("start pair not two preamble nibbles");

	property p_kill_dv;
		@(posedge mclk) disable iff (reset)
		!sig |=> !mii_rx.dv [*2];
	endproperty
	a_kill_dv: assert property (p_kill_dv) // [RULE12]
		else $error("valid held without signal");

	property p_no_an;
		@(posedge mclk) disable iff (reset)
		lk_st == LK_READY && !an_enable && sig |=> lk_st == LK_UP;
	endproperty
	a_no_an: assert property (p_no_an) // [RULE17]
		else $error("ready did not go up without negotiation");

	property p_bad_nib;
		@(posedge mclk) disable iff (reset)
		bad_stb && !kill |=> rx_nib_stb && mii_rx.er && mii_rx.rxd == BAD_NIB;
	endproperty
	a_bad_nib: assert property (p_bad_nib) // [RULE21]
		else $error("bad start nibble wrong");

	property p_link_out;
		@(posedge mclk) disable iff (reset)
		(link_up || link10_ok) |=> link_status && !link_activity_led_n;
	endproperty
	a_link_out: assert property (p_link_out) // [RULE15]
		else $error("link status not reported");
endmodule
`default_nettype wire

// file: dv/ferp_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module ferp_line_model
	import ferp_pkg::*;
(
	// clock
	input wire logic mclk,
	// recovered line towards the receive logic
	output logic rx_nrzi,
	output logic rx_bit_toggle
);
	logic [LFSR_W-1:0] scr;
	logic key;

	// quiet line, scrambler seeded with a nonzero state
	initial begin
		rx_nrzi = 1'h0;
		rx_bit_toggle = 1'h0;
		scr = 11'h5a3;
	end

	// one plain bit: scramble, nrzi encode, mark it by a toggle
	task automatic send_bit(input logic plain);
		@(posedge mclk);
		#2;
		key = scr[TAP_A] ^ scr[TAP_B];
		scr = {scr[LFSR_W-2:0], key};
		rx_nrzi = rx_nrzi ^ (plain ^ key);
		rx_bit_toggle = ~rx_bit_toggle;
		repeat (3) @(posedge mclk);
		#2;
	endtask

	// one code group, first line bit from the msb
	task automatic send_group(input logic [4:0] grp);
		for (int i = 4; i >= 0; i--) begin
			send_bit(grp[i]);
		end
	endtask

	// idle stream is plain ones
	task automatic send_idle(input int n);
		repeat (n) send_bit(1'h1);
	endtask

	// fault idle: a run of ones closed by one zero
	task automatic send_fefi;
		send_idle(FEFI_ONES);
		send_bit(1'h0);
	endtask
endmodule
`default_nettype wire

// file: dv/test_ferp_rx_pcs.sv
`timescale 1ns/1ps
`default_nettype none
module test_ferp_rx_pcs
	import ferp_pkg::*;
;
	localparam int HOLD_T = 200;
	localparam int READY_T = 50;
	logic mclk, reset, signal_detect, an_enable;
	logic an_permit, link10_ok, tx_active, repeater_mode;
	logic rx_nrzi, rx_bit_toggle, rx_nib_stb, link_status;
	logic link_activity_led_n, tx_allow, descr_locked, far_end_fault;
	ferp_mii_rx_t mii_rx;
	int errors = 0;
	int n_tests = 0;
	int enc_bad = 0;
	logic [5:0] nq[$];
	logic [5:0] exp_pk[4] = '{6'h16, 6'h16, 6'h06, 6'h2a};

	// clock
	always #12.5 mclk = ~mclk;

	ferp_rx_pcs #(.HOLD_CYCLES(HOLD_T), .READY_CYCLES(READY_T)) DUT (
		.mclk(mclk),
		.reset(reset),
		.rx_nrzi(rx_nrzi),
		.rx_bit_toggle(rx_bit_toggle),
		.signal_detect(signal_detect),
		.an_enable(an_enable),
		.an_permit(an_permit),
		.link10_ok(link10_ok),
		.tx_active(tx_active),
		.repeater_mode(repeater_mode),
		.mii_rx(mii_rx),
		.rx_nib_stb(rx_nib_stb),
		.link_status(link_status),
		.link_activity_led_n(link_activity_led_n),
		.tx_allow(tx_allow),
		.descr_locked(descr_locked),
		.far_end_fault(far_end_fault)
	);

	ferp_line_model line (
		.mclk(mclk),
		.rx_nrzi(rx_nrzi),
		.rx_bit_toggle(rx_bit_toggle)
	);

	// collect nibbles; note valid seen without carrier
	always @(posedge mclk) begin
		if (rx_nib_stb === 1'h1) begin
			nq.push_back({mii_rx.rxd, mii_rx.dv, mii_rx.er});
		end
		if (mii_rx.dv === 1'h1 && mii_rx.crs !== 1'h1) begin
			enc_bad++;
		end
	end

	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// lock on idle, then link-up waits for negotiation
	task automatic t_link_lock;
		signal_detect = 1'h1;
		line.send_idle(30);
		check("lock early", descr_locked, 1'h0);
		line.send_idle(30);
		check("locked", descr_locked, 1'h1);
		check("ready wait", link_status, 1'h0);
		check("tx blocked", tx_allow, 1'h0);
		an_permit = 1'h1;
		settle(3);
		check("link up", link_status, 1'h1);
		check("tx up", tx_allow, 1'h1);
		check("led on", link_activity_led_n, 1'h0);
		line.send_idle(80);
		check("lock held", descr_locked, 1'h1);
	endtask

	// start pair, two data groups, a bad group, end pair
	task automatic t_packet;
		nq.delete();
		line.send_group(5'h18);
		line.send_group(5'h11);
		line.send_group(5'h09);
		line.send_group(5'h16);
		line.send_group(5'h01);
		line.send_group(5'h0d);
		line.send_group(5'h07);
		line.send_idle(20);
		check("nibbles", nq.size(), 5);
		for (int i = 0; i < 4; i++) begin
			check("nibble", nq[i], exp_pk[i]);
		end
		check("bad group", nq[4][1:0], 2'h3);
		check("end valid", mii_rx.dv, 1'h0);
		check("end crs", mii_rx.crs, 1'h0);
		check("enclose", enc_bad, 0);
	endtask

	// carrier without a start pair
	task automatic t_bad_start;
		nq.delete();
		// ten bits of search, then two group periods of bad start
		repeat (5) line.send_group(5'h15);
		check("bad crs", mii_rx.crs, 1'h1);
		check("bad er", mii_rx.er, 1'h1);
		check("bad nibble", nq[0], 6'h39);
		line.send_idle(20);
		check("bad er off", mii_rx.er, 1'h0);
		check("bad crs off", mii_rx.crs, 1'h0);
	endtask

	// transmit adds carrier only in switch mode
	task automatic t_carrier_mode;
		tx_active = 1'h1;
		settle(3);
		check("rep crs", mii_rx.crs, 1'h0);
		repeater_mode = 1'h0;
		settle(3);
		check("sw crs", mii_rx.crs, 1'h1);
		tx_active = 1'h0;
		settle(3);
	endtask

	task automatic t_far_fault;
		// a leading zero frames the first run of ones
		line.send_bit(1'h0);
		line.send_fefi();
		settle(3);
		check("fefi on", far_end_fault, 1'h1);
		line.send_idle(90);
		check("fefi off", far_end_fault, 1'h0);
	endtask

	// line stops: hold timer runs out, lock and link drop
	task automatic t_hold_expiry;
		settle(HOLD_T - 20);
		check("hold run", descr_locked, 1'h1);
		settle(70);
		check("hold out", descr_locked, 1'h0);
		check("hold tx", tx_allow, 1'h0);
		line.send_idle(60);
		check("relock", descr_locked, 1'h1);
		check("relink", link_status, 1'h1);
	endtask

	// signal lost mid-packet, then other paths to link
	task automatic t_signal_loss;
		line.send_group(5'h18);
		line.send_group(5'h11);
		line.send_group(5'h09);
		signal_detect = 1'h0;
		settle(4);
		check("nosig dv", mii_rx.dv, 1'h0);
		check("nosig link", link_status, 1'h0);
		check("nosig led", link_activity_led_n, 1'h1);
		link10_ok = 1'h1;
		settle(3);
		check("link10", link_status, 1'h1);
		check("link10 led", link_activity_led_n, 1'h0);
		link10_ok = 1'h0;
		an_enable = 1'h0;
		an_permit = 1'h0;
		signal_detect = 1'h1;
		line.send_idle(60);
		check("no an up", tx_allow, 1'h1);
	endtask

	// watchdog against a hang
	initial begin
		repeat (40000) @(posedge mclk);
		errors++;
		$display("BAD watchdog expected done seen hang");
		report_and_stop();
	end

	// main sequence
	initial begin
		mclk = 1'h0;
		reset = 1'h1;
		signal_detect = 1'h0;
		an_enable = 1'h1;
		an_permit = 1'h0;
		link10_ok = 1'h0;
		tx_active = 1'h0;
		repeater_mode = 1'h1;
		repeat (8) @(posedge mclk);
		#2;
		check("reset", {mii_rx, rx_nib_stb, link_status, link_activity_led_n,
			tx_allow, descr_locked, far_end_fault}, 13'h0008);
		reset = 1'h0;
		settle(3);
		t_link_lock();
		t_packet();
		t_bad_start();
		t_carrier_mode();
		t_far_fault();
		t_hold_expiry();
		t_signal_loss();
		report_and_stop();
	end
endmodule
`default_nettype wire
